/* design/sibdec_consts.vh */
// Constants for the operand field decoder: field codes, selector codes, register layout.
// Included by the decoder modules; definitions only.
`ifndef SIBDEC_CONSTS_VH
`define SIBDEC_CONSTS_VH

// Addressing form codes
`define SIBDEC_FORM_NODISP 2'h0
`define SIBDEC_FORM_DISP8 2'h1
`define SIBDEC_FORM_DISP32 2'h2
`define SIBDEC_FORM_REG 2'h3
// Locator and index/base special codes
`define SIBDEC_RM_SIB 3'h4
`define SIBDEC_IDX_NONE 3'h4
`define SIBDEC_BASE_STACK 3'h4
`define SIBDEC_BASE_FRAME 3'h5
// Segment select codes
`define SIBDEC_SEG_DATA 1'h0
`define SIBDEC_SEG_STACK 1'h1
// Special register classes
`define SIBDEC_CLS_CTRL 2'h0
`define SIBDEC_CLS_DEBUG 2'h1
`define SIBDEC_CLS_TEST 2'h2
// Condition test codes (upper three bits)
`define SIBDEC_TST_OVF 3'h0
`define SIBDEC_TST_BELOW 3'h1
`define SIBDEC_TST_ZERO 3'h2
`define SIBDEC_TST_BEQ 3'h3
`define SIBDEC_TST_SIGN 3'h4
`define SIBDEC_TST_PAR 3'h5
`define SIBDEC_TST_LESS 3'h6
`define SIBDEC_TST_LEQ 3'h7
// Flag vector bit positions
`define SIBDEC_FLG_CARRY 0
`define SIBDEC_FLG_PARITY 1
`define SIBDEC_FLG_ZERO 2
`define SIBDEC_FLG_SIGN 3
`define SIBDEC_FLG_OVF 4
// Register map, byte addresses
`define SIBDEC_OFF_MODRM 12'h000
`define SIBDEC_OFF_SIB 12'h004
`define SIBDEC_OFF_DISP 12'h008
`define SIBDEC_OFF_GPR0 12'h020
`define SIBDEC_OFF_EA 12'h040
`define SIBDEC_OFF_SEG 12'h044
`define SIBDEC_OFF_CTRL 12'h048
`define SIBDEC_OFF_IMM 12'h04C
`define SIBDEC_OFF_STAT 12'h050
`define SIBDEC_OFF_SPEC 12'h054
// Reset values
`define SIBDEC_RST_WORD 32'h00000000
`endif

/* design/sibdec_cond.v */
// Condition test evaluator for the four-bit conditional field.
// Assumes flags arrive in the layout given by the constants header.
`include "sibdec_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module sibdec_cond (
	// Inputs
	input wire [3:0] code_i,
	input wire [4:0] flags_i,
	// Result
	output reg taken_o
);
	reg raw;
	wire cf;
	wire pf;
	wire zf;
	wire sf;
	wire of;
	assign cf = flags_i[`SIBDEC_FLG_CARRY];
	assign pf = flags_i[`SIBDEC_FLG_PARITY];
	assign zf = flags_i[`SIBDEC_FLG_ZERO];
	assign sf = flags_i[`SIBDEC_FLG_SIGN];
	assign of = flags_i[`SIBDEC_FLG_OVF];
	always @* begin
		case (code_i[3:1]) // RULE14
			`SIBDEC_TST_OVF: raw = of; // RULE15
			`SIBDEC_TST_BELOW: raw = cf; // RULE15
			`SIBDEC_TST_ZERO: raw = zf; // RULE15
			`SIBDEC_TST_BEQ: raw = cf | zf; // RULE15
			`SIBDEC_TST_SIGN: raw = sf; // RULE16
			`SIBDEC_TST_PAR: raw = pf; // RULE16
			`SIBDEC_TST_LESS: raw = sf ^ of; // RULE16
			`SIBDEC_TST_LEQ: raw = (sf ^ of) | zf; // RULE16
			default: raw = 1'b0;
		endcase
		taken_o = raw ^ code_i[0]; // RULE14
	end
endmodule // sibdec_cond
`default_nettype wire

/* design/sibdec_top.v */
// Operand field decoder: addressing bytes, direction, sign extend, condition, special regs.
// Assumes an APB master on the same clock; software loads fields and register values.
//
// Register access over APB and the placing of the registers were left to the implementer.
`include "sibdec_consts.vh"
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1 - Locator 100 in a memory form with 32-bit addressing means a SIB byte follows.
// RULE2 - Form comes from the first byte; scale, index, base from the SIB byte.
// RULE3 - Scale codes 00..11 multiply index by 1, 2, 4, 8.
// RULE4 - Index codes pick registers 0..7; code 100 means no index.
// RULE5 - Software keeps scale zero when no index; otherwise address undefined.
// RULE6 - Forms 00/01/10 add none, sign-extended byte, dword displacement; data segment.
// RULE7 - Base 100 is the stack pointer with stack segment.
// RULE8 - Base 101: form 00 no base plus dword; else frame base, stack segment.
// RULE9 - Direction bit decides which operand is source and destination.
// RULE10 - Direction 0: register field is source, addressed operand destination.
// RULE11 - Direction 1: register field is destination, addressed operand source.
// RULE12 - Sign extension applies only to byte immediates into wider destinations.
// RULE13 - Sign bit 1 extends the byte immediate; 0 leaves it unextended.
// RULE14 - Upper three condition bits choose the test; low bit negates.
// RULE15 - Codes 000x overflow, 001x below, 010x zero, 011x below-or-equal.
// RULE16 - Codes 100x sign, 101x parity, 110x less, 111x less-or-equal.
// RULE17 - Control selector 000, 010, 011 pick control registers 0, 2, 3.
// RULE18 - Debug selector 000..011 pick 0..3; 110 and 111 pick 6, 7.
// RULE19 - Test selector 110 and 111 pick test registers 6, 7.
// RULE20 - Software uses only listed selector codes per class.
// RULE21 - Effective address sums wrap modulo two to the thirty-second.
module sibdec_top #(
	parameter ADDR_W = 12
) (
	// Clock and reset
	input wire MCLK_I,
	input wire SRST_I,
	// APB slave
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [ADDR_W-1:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output reg [31:0] PRDATA_O,
	output reg PREADY_O,
	output reg PSLVERR_O,
	// Decode results
	output reg [31:0] EA_O,
	output reg SEG_STACK_O,
	output reg SIB_NEEDED_O,
	output reg COND_TAKEN_O
);
	////////////////////////////////////////////////////////////////////////////////
	// Registers
	reg [7:0] modrm_ff;
	reg [7:0] sib_ff;
	reg [31:0] disp_ff;
	reg [31:0] gpr_ff [0:7];
	reg [31:0] ctrl_ff;
	reg [31:0] nxt_ea;
	reg nxt_seg;
	reg nxt_sib;
	reg [31:0] nxt_imm;
	reg [31:0] imm_ff;
	reg [31:0] nxt_rdata;
	reg nxt_err;
	reg [3:0] nxt_spec;
	reg nxt_spec_ok;
	reg [3:0] spec_ff;
	reg [1:0] ops_ff;
	wire cond_taken;
	integer i;

	// Control word and addressing byte fields
	wire [3:0] tttn;
	wire [4:0] flags;
	wire dir_bit;
	wire sext_bit;
	wire imm_is_byte;
	wire dst_wide;
	wire dst_dword;
	wire [1:0] spec_cls;
	wire [2:0] spec_sel;
	assign tttn = ctrl_ff[3:0];
	assign flags = ctrl_ff[8:4];
	assign dir_bit = ctrl_ff[9];
	assign sext_bit = ctrl_ff[10];
	assign imm_is_byte = ctrl_ff[11];
	assign dst_wide = ctrl_ff[12];
	assign dst_dword = ctrl_ff[13];
	assign spec_cls = ctrl_ff[15:14];
	assign spec_sel = ctrl_ff[18:16];
	wire [1:0] form;
	wire [2:0] rm;
	wire [1:0] scale;
	wire [2:0] idx;
	wire [2:0] base;
	assign form = modrm_ff[7:6]; // RULE2
	assign rm = modrm_ff[2:0];
	assign scale = sib_ff[7:6]; // RULE2
	assign idx = sib_ff[5:3];
	assign base = sib_ff[2:0];

	////////////////////////////////////////////////////////////////////////////////
	// Address arithmetic
	function [31:0] scaled_index;
		input [31:0] val;
		input [1:0] sc;
		begin
			scaled_index = val << sc; // RULE3
		end
	endfunction

	function [31:0] sext8;
		input [7:0] b;
		begin
			sext8 = {{24{b[7]}}, b};
		end
	endfunction

	reg [31:0] base_val;
	reg [31:0] idx_val;
	reg [31:0] disp_val;
	always @* begin
		nxt_sib = (form != `SIBDEC_FORM_REG) && (rm == `SIBDEC_RM_SIB); // RULE1
		base_val = 32'h00000000;
		idx_val = 32'h00000000;
		disp_val = 32'h00000000;
		nxt_seg = `SIBDEC_SEG_DATA; // RULE6
		case (form)
			`SIBDEC_FORM_DISP8: disp_val = sext8(disp_ff[7:0]); // RULE6
			`SIBDEC_FORM_DISP32: disp_val = disp_ff; // RULE6
			default: disp_val = 32'h00000000;
		endcase
		if (nxt_sib) begin
			// Scale with no index is left unchecked: result undefined anyway
			if (idx != `SIBDEC_IDX_NONE) begin
				idx_val = scaled_index(gpr_ff[idx], scale); // RULE4
			end
			if (base == `SIBDEC_BASE_STACK) begin
				base_val = gpr_ff[`SIBDEC_BASE_STACK]; // RULE7
				nxt_seg = `SIBDEC_SEG_STACK; // RULE7
			end else if (base == `SIBDEC_BASE_FRAME && form == `SIBDEC_FORM_NODISP) begin
				disp_val = disp_ff; // RULE8
			end else if (base == `SIBDEC_BASE_FRAME) begin
				base_val = gpr_ff[`SIBDEC_BASE_FRAME]; // RULE8
				nxt_seg = `SIBDEC_SEG_STACK; // RULE8
			end else begin
				base_val = gpr_ff[base];
			end
		end else if (form == `SIBDEC_FORM_REG) begin
			base_val = gpr_ff[rm];
		end else if (rm == `SIBDEC_BASE_FRAME && form == `SIBDEC_FORM_NODISP) begin
			disp_val = disp_ff;
		end else begin
			base_val = gpr_ff[rm];
			if (rm == `SIBDEC_BASE_FRAME) begin
				nxt_seg = `SIBDEC_SEG_STACK;
			end
		end
		nxt_ea = base_val + idx_val + disp_val; // RULE21
	end

	////////////////////////////////////////////////////////////////////////////////
	// Immediate and special register selection
	always @* begin
		nxt_imm = disp_ff;
		if (imm_is_byte) begin
			nxt_imm = {24'h000000, disp_ff[7:0]}; // RULE13
			if (sext_bit && dst_wide) begin // RULE12
				// Word destination keeps upper half clear
				nxt_imm = dst_dword ? sext8(disp_ff[7:0]) :
					{16'h0000, {8{disp_ff[7]}}, disp_ff[7:0]}; // RULE13
			end
		end
		nxt_spec = {1'b0, spec_sel};
		nxt_spec_ok = 1'b0;
		case (spec_cls)
			`SIBDEC_CLS_CTRL: nxt_spec_ok = (spec_sel == 3'h0) || (spec_sel == 3'h2) ||
				(spec_sel == 3'h3); // RULE17
			`SIBDEC_CLS_DEBUG: nxt_spec_ok = (spec_sel[2] == 1'b0) ||
				(spec_sel[2:1] == 2'h3); // RULE18
			`SIBDEC_CLS_TEST: nxt_spec_ok = (spec_sel[2:1] == 2'h3); // RULE19
			default: nxt_spec_ok = 1'b0;
		endcase
		if (!nxt_spec_ok) begin
			// Unlisted codes are flagged instead of trusted
			nxt_spec = 4'hF;
		end
	end

	sibdec_cond u_cond (
		.code_i(tttn),
		.flags_i(flags),
		.taken_o(cond_taken)
	);

	////////////////////////////////////////////////////////////////////////////////
	// APB access
	wire acc;
	assign acc = PSEL_I && PENABLE_I && !PREADY_O;
	always @* begin
		nxt_rdata = `SIBDEC_RST_WORD;
		nxt_err = 1'b0;
		if (PADDR_I >= `SIBDEC_OFF_GPR0 && PADDR_I < `SIBDEC_OFF_GPR0 + 12'h020 &&
			PADDR_I[1:0] == 2'h0) begin
			nxt_rdata = gpr_ff[PADDR_I[4:2]];
		end else begin
			case (PADDR_I)
				`SIBDEC_OFF_MODRM: nxt_rdata = {24'h000000, modrm_ff};
				`SIBDEC_OFF_SIB: nxt_rdata = {24'h000000, sib_ff};
				`SIBDEC_OFF_DISP: nxt_rdata = disp_ff;
				`SIBDEC_OFF_EA: nxt_rdata = EA_O;
				`SIBDEC_OFF_SEG: nxt_rdata = {31'h00000000, SEG_STACK_O};
				`SIBDEC_OFF_CTRL: nxt_rdata = ctrl_ff;
				`SIBDEC_OFF_IMM: nxt_rdata = imm_ff;
				`SIBDEC_OFF_STAT: nxt_rdata = {28'h0000000, ops_ff, COND_TAKEN_O, SIB_NEEDED_O};
				`SIBDEC_OFF_SPEC: nxt_rdata = {28'h0000000, spec_ff};
				default: nxt_err = 1'b1;
			endcase
			if (PWRITE_I && (PADDR_I == `SIBDEC_OFF_EA || PADDR_I == `SIBDEC_OFF_SEG ||
				PADDR_I == `SIBDEC_OFF_IMM || PADDR_I == `SIBDEC_OFF_STAT ||
				PADDR_I == `SIBDEC_OFF_SPEC)) begin
				nxt_err = 1'b1;
			end
		end
	end

	always @(posedge MCLK_I) begin
		if (SRST_I) begin
			modrm_ff <= 8'h00;
			sib_ff <= 8'h00;
			disp_ff <= `SIBDEC_RST_WORD;
			ctrl_ff <= `SIBDEC_RST_WORD;
			for (i = 0; i < 8; i = i + 1) begin
				gpr_ff[i] <= `SIBDEC_RST_WORD;
			end
			PRDATA_O <= `SIBDEC_RST_WORD;
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O <= acc;
			PSLVERR_O <= acc && nxt_err;
			PRDATA_O <= (acc && !PWRITE_I) ? nxt_rdata : `SIBDEC_RST_WORD;
			if (acc && PWRITE_I && !nxt_err) begin
				case (PADDR_I)
					`SIBDEC_OFF_MODRM: modrm_ff <= PWDATA_I[7:0];
					`SIBDEC_OFF_SIB: sib_ff <= PWDATA_I[7:0];
					`SIBDEC_OFF_DISP: disp_ff <= PWDATA_I;
					`SIBDEC_OFF_CTRL: ctrl_ff <= PWDATA_I;
					default: gpr_ff[PADDR_I[4:2]] <= PWDATA_I;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered results, one cycle behind the fields
	always @(posedge MCLK_I) begin
		if (SRST_I) begin
			EA_O <= `SIBDEC_RST_WORD;
			SEG_STACK_O <= 1'b0;
			SIB_NEEDED_O <= 1'b0;
			COND_TAKEN_O <= 1'b0;
			imm_ff <= `SIBDEC_RST_WORD;
			spec_ff <= 4'h0;
			ops_ff <= 2'h0;
		end else begin
			EA_O <= nxt_ea;
			SEG_STACK_O <= nxt_seg;
			SIB_NEEDED_O <= nxt_sib;
			COND_TAKEN_O <= cond_taken;
			imm_ff <= nxt_imm;
			spec_ff <= nxt_spec;
			// Bit0 source is reg field, bit1 destination is reg field
			ops_ff <= dir_bit ? 2'h2 : 2'h1; // RULE9 RULE10 RULE11
		end
	end
endmodule // sibdec_top
`default_nettype wire

/* dv/sibdec_properties.sv */
// Port checker for the operand field decoder.
// Assumes a bind into sibdec_top; one clock, sync reset.
`timescale 1ns/10ps
`default_nettype none
module sibdec_properties #(parameter ADDR_W = 12) (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic SRST_I,
	// Bus
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	// Results
	input wire logic [31:0] EA_O,
	input wire logic SEG_STACK_O,
	input wire logic SIB_NEEDED_O
);
	wire tk = PSEL_I && PENABLE_I && !PREADY_O;
	wire wa = tk && PWRITE_I;
	logic [7:0] mb_ff, sb_ff;
	// Shadow of the addressing bytes
	always @(posedge MCLK_I) begin
		if (SRST_I) begin
			mb_ff <= 8'h00;
			sb_ff <= 8'h00;
		end else begin
			if (wa && PADDR_I == 12'h000)
				mb_ff <= PWDATA_I[7:0];
			if (wa && PADDR_I == 12'h004)
				sb_ff <= PWDATA_I[7:0];
		end
	end
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (SRST_I);
	a_ready_answer: assert property (tk |=> PREADY_O)
		else $error("ready missing");
	a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready held");
	a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
		else $error("read data outside answer");
	a_err_unmapped: assert property (tk && PADDR_I > 12'h054 |=> PSLVERR_O && PREADY_O)
		else $error("unmapped not refused");
	a_err_readonly: assert property (wa && PADDR_I inside {12'h040, 12'h044, 12'h04C,
		12'h050, 12'h054} |=> PSLVERR_O)
		else $error("read-only write not refused");
	a_ea_readback: assert property (tk && !PWRITE_I && PADDR_I == 12'h040
		|=> PRDATA_O == EA_O && !PSLVERR_O)
		else $error("address readback differs");
	a_sib_flag: assert property (wa && PADDR_I == 12'h000 |-> ##2
		SIB_NEEDED_O == (mb_ff[7:6] != 2'h3 && mb_ff[2:0] == 3'h4))
		else $error("sib flag wrong");
	a_seg_default: assert property (wa && PADDR_I == 12'h000 |-> ##2
		mb_ff[7:6] == 2'h3 || mb_ff[2:0] != 3'h4 || SEG_STACK_O == (sb_ff[2:0] == 3'h4
		|| sb_ff[2:0] == 3'h5 && mb_ff[7:6] != 2'h0))
		else $error("segment wrong");
endmodule // sibdec_properties
bind sibdec_top sibdec_properties #(.ADDR_W(ADDR_W)) u_props (.MCLK_I(MCLK_I),
	.SRST_I(SRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
	.PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O), .EA_O(EA_O), .SEG_STACK_O(SEG_STACK_O),
	.SIB_NEEDED_O(SIB_NEEDED_O));
`default_nettype wire

/* dv/sibdec_feeder.sv */
// Feeder standing in for the prefetch and address logic.
// Assumes one clock; the bench calls xfer per access.
`timescale 1ns/10ps
`default_nettype none
module sibdec_feeder (
	// Clock and answer
	input wire logic clk_i,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	// Request
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [11:0] paddr_o,
	output logic [31:0] pwdata_o
);
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h0;
		pwdata_o = 32'h0;
	end
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		do @(posedge clk_i); while (pready_i !== 1'b1);
		r = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// Released lines must not look valid
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask
endmodule // sibdec_feeder
`default_nettype wire

/* dv/test_sib_and_opcode_field_decoder.sv */
// Self-checking bench for the operand field decoder.
// Assumes the feeder drives the bus; a model here predicts results.
`timescale 1ns/10ps
`default_nettype none
module test_sib_and_opcode_field_decoder;
	logic mclk, srst, psel, pen, pwr, prdy, perr, seg, sibn, ctk, er;
	logic [11:0] padr;
	logic [31:0] pwd, prd, ea, rd, e, x, dp, c;
	logic [31:0] gpr[8];
	logic [4:0] vs[11] = '{5'h00, 5'h08, 5'h0C, 5'h01, 5'h05, 5'h09, 5'h0D, 5'h19, 5'h1D,
		5'h1A, 5'h1E};
	logic [1:0] f, sc;
	logic [2:0] ix, bs;
	int num_errors = 0;
	int tests_run = 0;
	integer seed = 32'h29D8A1CE;
	sibdec_top dut (.MCLK_I(mclk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
		.PSLVERR_O(perr), .EA_O(ea), .SEG_STACK_O(seg), .SIB_NEEDED_O(sibn),
		.COND_TAKEN_O(ctk));
	sibdec_feeder bus (.clk_i(mclk), .prdata_i(prd), .pready_i(prdy), .pslverr_i(perr),
		.psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(padr), .pwdata_o(pwd));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		#1500000;
		num_errors++;
		end_sim;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// A read compares against d
	task io(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee);
		bus.xfer(w, a, d, rd, er);
		if (!w)
			chk(rd, d);
		chk({31'h0, er}, {31'h0, ee});
	endtask
	task end_sim;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	function automatic logic cnd(input logic [3:0] t, input logic [4:0] g);
		logic [7:0] v;
		v = {(g[3] ^ g[4]) | g[2], g[3] ^ g[4], g[1], g[3], g[0] | g[2], g[2], g[0], g[4]};
		return v[t[3:1]] ^ t[0];
	endfunction
	initial begin
		srst = 1'b1;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		io(1'b0, 12'h000, 32'h0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			gpr[i] = $random(seed);
			io(1'b1, 12'(32 + 4 * i), gpr[i], 1'b0);
		end
		for (int i = 0; i < 32; i++) begin
			{f, bs} = 5'(i);
			{sc, ix} = 5'($random(seed));
			dp = $random(seed);
			if (ix == 3'h4)
				sc = 2'h0;
			x = (ix == 3'h4) ? 32'h0 : gpr[ix] << sc;
			e = (bs == 3'h5 && f == 2'h0) ? dp : gpr[bs];
			e = e + x + (f == 2'h1 ? {{24{dp[7]}}, dp[7:0]} : f == 2'h2 ? dp : 32'h0);
			if (f == 2'h3)
				e = gpr[4];
			io(1'b1, 12'h008, dp, 1'b0);
			io(1'b1, 12'h004, {24'h0, sc, ix, bs}, 1'b0);
			io(1'b1, 12'h000, {24'h0, f, 6'h04}, 1'b0);
			@(posedge mclk);
			chk(ea, e);
			chk({31'h0, sibn}, {31'h0, f != 2'h3});
			if (f != 2'h3)
				chk({31'h0, seg}, {31'h0, bs == 3'h4 || bs == 3'h5 && f != 2'h0});
		end
		// Locator 101 without a SIB byte: plain 32-bit table
		for (int i = 0; i < 3; i++) begin
			f = 2'(i);
			io(1'b1, 12'h000, {24'h0, f, 6'h05}, 1'b0);
			@(posedge mclk);
			e = (f == 2'h0) ? dp : gpr[5] + (f == 2'h1 ? {{24{dp[7]}}, dp[7:0]} : dp);
			chk(ea, e);
			chk({31'h0, sibn}, 32'h0);
			chk({31'h0, seg}, {31'h0, f != 2'h0});
		end
		io(1'b1, 12'h040, ~e, 1'b1);
		io(1'b0, 12'h040, e, 1'b0);
		io(1'b1, 12'h0FC, e, 1'b1);
		io(1'b1, 12'h000, 32'h04, 1'b0);
		for (int i = 0; i < 44; i++) begin
			c = $random(seed);
			c[13] = c[13] & c[12];
			c[3:0] = 4'(i);
			c[18:14] = vs[i % 11];
			c[31:19] = 13'h0;
			dp = $random(seed);
			io(1'b1, 12'h008, dp, 1'b0);
			io(1'b1, 12'h048, c, 1'b0);
			@(posedge mclk);
			chk({31'h0, ctk}, {31'h0, cnd(c[3:0], c[8:4])});
			io(1'b0, 12'h050, {28'h0, c[9] ? 2'h2 : 2'h1, cnd(c[3:0], c[8:4]), 1'b1}, 1'b0);
			x = c[10] && c[13] ? {{24{dp[7]}}, dp[7:0]} : {24'h0, dp[7:0]};
			if (c[10] && c[12] && !c[13])
				x = {16'h0, {8{dp[7]}}, dp[7:0]};
			io(1'b0, 12'h04C, c[11] ? x : dp, 1'b0);
			io(1'b0, 12'h054, {29'h0, c[18:16]}, 1'b0);
		end
		end_sim;
	end
endmodule // test_sib_and_opcode_field_decoder
`default_nettype wire
